/* logic/ddjc_pkg.sv */
// Shared constants for the decade Johnson counter
package ddjc_pkg;
    localparam int STAGES = 5;
    localparam int OUTPUTS = 10;
    localparam int CARRY_LAST = 4;
    localparam logic [4:0] JOHNSON_ZERO = 5'h00;
    localparam logic [9:0] ONE_HOT_ZERO = 10'h001;
    localparam logic [0:0] CARRY_RESET = 1'h1;
    localparam logic [0:0] EDGE_RESET = 1'h0;
    localparam logic [0:0] ENABLE_RESET = 1'h1;
endpackage

/* logic/ddjc_decode.sv */
// Johnson state to one-hot count decoder
`timescale 1ns/1ps
module ddjc_decode (
    input wire logic [4:0] i_state,
    output logic [9:0] o_one_hot
);
    // Each count is marked by one adjacent bit pair of the twisted ring
    always_comb begin
        o_one_hot[0] = ~i_state[4] & ~i_state[0];
        o_one_hot[5] = i_state[4] & i_state[0];
        for (int k = 1; k < 5; k++) begin
            o_one_hot[k] = i_state[k - 1] & ~i_state[k];
            o_one_hot[k + 5] = ~i_state[k - 1] & i_state[k];
        end
    end
endmodule

/* logic/ddjc_counter.sv */
// Decade Johnson counter with decoded outputs and wrap flag
`timescale 1ns/1ps
// Functional notes
// - Five-stage Johnson state, decoded to ten outputs
// - Rising clock advances while inhibit low
// - Inhibit high freezes the count
// - Falling inhibit advances while clock high
// - Reset forces zero state asynchronously
// - Exactly one decoded output high
// - Wrap flag high for counts zero to four
// - Flag falls at five, rises at zero
// - Flag rising edge clocks next stage
// - Decoded outputs step without gaps
module ddjc_counter (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_count_clk,
    input wire logic i_count_inhibit_n,
    output logic [9:0] o_one_hot_count_outputs,
    output logic o_stage_wrap_flag
);
    logic [4:0] johnson_reg;
    logic [4:0] johnson_next;
    logic count_clk_reg;
    logic inhibit_n_reg;
    logic [9:0] one_hot_next;
    logic [9:0] one_hot_reg;
    logic wrap_next;
    logic wrap_reg;
    logic rise_adv;
    logic fall_adv;
    logic advance;

    // Rising count clock steps only while the inhibit pin is low
    assign rise_adv = i_count_clk & ~count_clk_reg & ~i_count_inhibit_n;

    // Falling inhibit steps only while the count clock pin is high
    assign fall_adv = ~i_count_inhibit_n & inhibit_n_reg & i_count_clk;

    // Both edges seen in one cycle still make a single step
    assign advance = rise_adv | fall_adv;

    // Twisted ring: inverted last stage feeds the first
    assign johnson_next = advance ? {johnson_reg[3:0], ~johnson_reg[4]} : johnson_reg;

    // Wrap flag taken from the next count so it moves together with the outputs
    assign wrap_next = |one_hot_next[ddjc_pkg::CARRY_LAST:0];

    // Previous pin levels for edge detection; they reset to the idle levels
    // so that a release of reset with idle pins never looks like an edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_clk_reg <= ddjc_pkg::EDGE_RESET;
            inhibit_n_reg <= ddjc_pkg::ENABLE_RESET;
        end else begin
            count_clk_reg <= i_count_clk;
            inhibit_n_reg <= i_count_inhibit_n;
        end
    end

    // Count state; reset wins over any edge in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            johnson_reg <= ddjc_pkg::JOHNSON_ZERO;
        end else begin
            johnson_reg <= johnson_next;
        end
    end

    // Ten-way decode of the next ring state
    ddjc_decode u_decode (
        .i_state(johnson_next),
        .o_one_hot(one_hot_next)
    );

    // Decoded outputs are registered from the next state, so they track the count
    // with no lag and never show the decode spikes of a rippling ring
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            one_hot_reg <= ddjc_pkg::ONE_HOT_ZERO;
        end else begin
            one_hot_reg <= one_hot_next;
        end
    end

    // Wrap flag register; its rising edge is what clocks a cascaded stage
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wrap_reg <= ddjc_pkg::CARRY_RESET;
        end else begin
            wrap_reg <= wrap_next;
        end
    end

    // Limitation: a decoded output fed back to reset clears the count at once,
    // so the pulse on that output is shorter than a count period
    assign o_one_hot_count_outputs = one_hot_reg;
    assign o_stage_wrap_flag = wrap_reg;

    // Checks, all on the system clock

    // The zero state stands at the first edge after reset is released
    a_reset_zero: assert property (
        @(posedge i_clk) $fell(i_rst)
        |-> (one_hot_reg == ddjc_pkg::ONE_HOT_ZERO && wrap_reg == ddjc_pkg::CARRY_RESET)
    ) else $error("reset did not give zero state");

    // Exactly one decoded output at every edge
    a_one_hot_only: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $onehot(one_hot_reg)
    ) else $error("decoded outputs not one-hot");

    // An output stays up for the whole count period, until the next step
    a_count_period: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !advance |=> $stable(one_hot_reg)
    ) else $error("decoded output moved without a step");

    // Wrap flag is high exactly for counts zero to four
    a_carry_decode: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wrap_reg == (|one_hot_reg[ddjc_pkg::CARRY_LAST:0])
    ) else $error("wrap flag disagrees with count");

    // Wrap flag may only fall on reaching five
    a_carry_falls_five: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $fell(wrap_reg) |-> one_hot_reg[5]
    ) else $error("wrap flag fell away from five");

    // Wrap flag may only rise on reaching zero
    a_carry_rises_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(wrap_reg) |-> one_hot_reg[0]
    ) else $error("wrap flag rose away from zero");

    // Inhibit held high freezes the count
    a_hold_inhibit: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_count_inhibit_n && inhibit_n_reg) |=> $stable(one_hot_reg)
    ) else $error("count moved while inhibited");

    // A count clock rise while inhibited is swallowed
    a_inhibit_blocks_rise: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_count_inhibit_n && i_count_clk && !count_clk_reg) |=> $stable(one_hot_reg)
    ) else $error("inhibited clock rise was counted");

    // A qualified clock rise steps the decoded outputs by one
    a_rise_step: assert property (
        @(posedge i_clk) disable iff (i_rst)
        rise_adv |=> one_hot_reg == {$past(one_hot_reg[8:0]), $past(one_hot_reg[9])}
    ) else $error("rising clock did not step");

    // With the count clock low neither mode can step
    a_clk_low_hold: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !i_count_clk |=> $stable(johnson_reg)
    ) else $error("ring moved with count clock low");

    // A qualified inhibit fall steps the decoded outputs by one
    a_fall_step: assert property (
        @(posedge i_clk) disable iff (i_rst)
        fall_adv |=> one_hot_reg == {$past(one_hot_reg[8:0]), $past(one_hot_reg[9])}
    ) else $error("falling inhibit did not step");

    // Each step shifts the ring and feeds back the inverted last stage
    a_ring_shift: assert property (
        @(posedge i_clk) disable iff (i_rst)
        advance |=> johnson_reg == {$past(johnson_reg[3:0]), ~$past(johnson_reg[4])}
    ) else $error("ring did not shift");

    // The next ring state always decodes to a single output
    a_johnson_legal: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $onehot(one_hot_next)
    ) else $error("illegal ring state");

    // A step from nine wraps to zero with the flag up
    a_wrap_order: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (advance && one_hot_reg[9]) |=> one_hot_reg[0] && wrap_reg
    ) else $error("nine did not wrap to zero");

    // A flag rise only follows count nine, so a next stage steps once per decade
    a_cascade_nine: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(wrap_reg) |-> $past(one_hot_reg[9])
    ) else $error("wrap flag rose without a wrap");

    // Every step lands on a new single output, with no empty cycle between
    a_gapless_step: assert property (
        @(posedge i_clk) disable iff (i_rst)
        advance |=> $onehot(one_hot_reg) && (one_hot_reg != $past(one_hot_reg))
    ) else $error("step left a gap in the outputs");

    // Count by a rising clock
    c_rise_count: cover property (
        @(posedge i_clk) disable iff (i_rst) rise_adv
    );

    // Count by a falling inhibit
    c_fall_count: cover property (
        @(posedge i_clk) disable iff (i_rst) fall_adv
    );

    // Wrap to zero raising the flag
    c_wrap: cover property (
        @(posedge i_clk) disable iff (i_rst) $rose(wrap_reg)
    );

    // Both edges in one cycle
    c_double_edge: cover property (
        @(posedge i_clk) disable iff (i_rst) rise_adv && fall_adv
    );

    // Release of reset
    c_reset_release: cover property (
        @(posedge i_clk) $fell(i_rst)
    );
endmodule

/* verification/ddjc_next_stage.sv */
// Cascaded next-stage model counting wrap flag rising edges
`timescale 1ns/1ps
module ddjc_next_stage (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_carry,
    output logic [3:0] o_tens
);
    logic carry_reg;
    // Rising carry clocks this stage, as a real next counter would
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            carry_reg <= 1'h1;
            o_tens <= 4'h0;
        end else begin
            carry_reg <= i_carry;
            if (i_carry && !carry_reg) o_tens <= o_tens + 4'h1;
        end
    end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the decade Johnson counter
`timescale 1ns/1ps
module testbench;
    logic i_clk = 0, i_rst = 1, i_count_clk = 0, i_count_inhibit_n = 1;
    logic [9:0] o_one_hot_count_outputs;
    logic o_stage_wrap_flag;
    logic [3:0] tens;
    int fail_count = 0, comparisons = 0, n = 0;
    always #12.5 i_clk = ~i_clk;
    ddjc_counter ddjc_counter_i (.i_clk(i_clk), .i_rst(i_rst), .i_count_clk(i_count_clk),
        .i_count_inhibit_n(i_count_inhibit_n), .o_one_hot_count_outputs(o_one_hot_count_outputs),
        .o_stage_wrap_flag(o_stage_wrap_flag));
    ddjc_next_stage ddjc_next_stage_i (.i_clk(i_clk), .i_rst(i_rst), .i_carry(o_stage_wrap_flag), .o_tens(tens));
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expect_count();
        check({o_stage_wrap_flag, o_one_hot_count_outputs}, {(n < 5) ? 1'h1 : 1'h0, 10'h001 << n});
    endtask
    // Rising count clock advances; wraps feed the next stage
    task automatic t_count();
        repeat (20) begin
            @(negedge i_clk) i_count_clk = 1;
            @(negedge i_clk) i_count_clk = 0;
            n = (n + 1) % 10;
            expect_count();
        end
        // The next stage sees the last wrap one clock later
        @(negedge i_clk);
        check({7'h0, tens}, 11'h002);
        $display("count done");
    endtask
    // Inhibit high must swallow clock edges
    task automatic t_freeze();
        @(negedge i_clk) i_count_inhibit_n = 1;
        repeat (3) begin
            @(negedge i_clk) i_count_clk = 1;
            @(negedge i_clk) i_count_clk = 0;
        end
        expect_count();
        // Clock rise and inhibit fall in one cycle count once
        @(negedge i_clk) i_count_clk = 1;
        i_count_inhibit_n = 0;
        @(negedge i_clk) i_count_clk = 0;
        i_count_inhibit_n = 1;
        n = (n + 1) % 10;
        expect_count();
        $display("freeze done");
    endtask
    // Falling inhibit counts with count clock held high
    task automatic t_alt();
        repeat (6) begin
            @(negedge i_clk) i_count_clk = 1;
            @(negedge i_clk) i_count_inhibit_n = 0;
            @(negedge i_clk) i_count_inhibit_n = 1;
            i_count_clk = 0;
            n = (n + 1) % 10;
            expect_count();
        end
        $display("alt done");
    endtask
    // Reset acts at once, without waiting for a clock edge
    task automatic t_reset();
        @(negedge i_clk) i_rst = 1;
        #2 n = 0;
        expect_count();
        @(negedge i_clk) i_rst = 0;
        // Counting resumes from zero after the release
        @(negedge i_clk) i_count_inhibit_n = 0;
        @(negedge i_clk) i_count_clk = 1;
        @(negedge i_clk) i_count_clk = 0;
        n = 1;
        expect_count();
        $display("reset done");
    endtask
    // Output four fed back to reset divides by four, with a short pulse on it
    task automatic t_divide();
        repeat (12) begin
            @(negedge i_clk) i_count_clk = 1;
            @(negedge i_clk) i_count_clk = 0;
            n = (n + 1) % 10;
            expect_count();
            if (o_one_hot_count_outputs[4] === 1'b1) begin
                i_rst = 1;
                #2 n = 0;
                expect_count();
                @(negedge i_clk) i_rst = 0;
            end
        end
        $display("divide done");
    endtask
    task automatic results();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge i_clk);
        i_rst = 0;
        @(negedge i_clk) i_count_inhibit_n = 0;
        t_count();
        t_freeze();
        t_alt();
        t_reset();
        t_divide();
        results();
    end
    initial begin
        #20000 fail_count++;
        results();
    end
endmodule
